//--- verilog/oprs_map.vh
// Address map, reset values and timing constants of the display reset and status block
`ifndef OPRS_MAP_VH
`define OPRS_MAP_VH
`define OPRS_ADDR_CTRL 8'h00
`define OPRS_ADDR_MODE 8'h04
`define OPRS_ADDR_MAP 8'h08
`define OPRS_ADDR_START 8'h0C
`define OPRS_ADDR_COL 8'h10
`define OPRS_ADDR_CONTRAST 8'h14
`define OPRS_ADDR_STATUS 8'h18
`define OPRS_ADDR_FRAME_DIV 8'h1C
`define OPRS_SEL_CTRL 0
`define OPRS_SEL_MODE 1
`define OPRS_SEL_MAP 2
`define OPRS_SEL_START 3
`define OPRS_SEL_COL 4
`define OPRS_SEL_CONTRAST 5
`define OPRS_SEL_STATUS 6
`define OPRS_SEL_FRAME_DIV 7
`define OPRS_STATUS_INIT_BIT 0
`define OPRS_STATUS_FRAME_BIT 1
`define OPRS_MODE_MSB 1
`define OPRS_MAP_MSB 2
`define OPRS_LINE_MSB 6
`define OPRS_CONTRAST_MSB 7
`define OPRS_DIV_MSB 15
`define OPRS_CTRL_DISP_ON_BIT 0
`define OPRS_CTRL_SOFT_INIT_BIT 1
`define OPRS_MAP_SEG_REMAP_BIT 0
`define OPRS_MAP_COM_REMAP_BIT 1
`define OPRS_MAP_COM_REV_BIT 2
`define OPRS_MODE_480X128 2'h0
`define OPRS_MAP_RST 3'h0
`define OPRS_START_RST 7'h00
`define OPRS_COL_RST 7'h00
`define OPRS_CONTRAST_RST 8'h7F
`define OPRS_FRAME_DIV_RST 16'h0FA0
`define OPRS_HTRANS_NONSEQ_BIT 1
`define OPRS_HSIZE_WORD 3'h2
`endif

//--- verilog/oprs_sync2.v
// Two flip-flop synchroniser for the reset pin
`timescale 1ns/100ps
module oprs_sync2 (
	input wire ref_clk_i,
	input wire sys_rst_i,
	input wire async_i,
	output reg sync_o
);
	reg meta_reg;
	always @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			meta_reg <= 1'b0;
			sync_o <= 1'b0;
		end else begin
			meta_reg <= async_i;
			sync_o <= meta_reg;
		end
	end
endmodule

//--- verilog/oprs_core.v
// Reset defaults, display state and frame-rate output of the display controller
`timescale 1ns/100ps
`include "oprs_map.vh"
module oprs_core (
	input wire ref_clk_i,
	input wire sys_rst_i,
	input wire hard_init_low_i,
	input wire hsel_i,
	input wire [7:0] haddr_i,
	input wire [1:0] htrans_i,
	input wire hwrite_i,
	input wire [2:0] hsize_i,
	input wire [31:0] hwdata_i,
	input wire hready_i,
	output reg [31:0] hrdata_o,
	output reg hreadyout_o,
	output reg hresp_o,
	output reg display_on_o,
	output reg [1:0] disp_mode_o,
	output reg [2:0] addr_map_o,
	output reg [6:0] start_line_o,
	output reg [6:0] col_addr_o,
	output reg [7:0] contrast_o,
	output reg frame_rate_pulse_out_o
);
	wire init_sync;
	wire hold_init;
	wire take;
	wire word_size;
	wire [7:0] rd_sel;
	wire [7:0] wr_sel;
	wire soft_init_next;
	wire frame_run;
	reg wr_pend_reg;
	reg [7:0] wr_addr_reg;
	reg soft_init_reg;
	reg [15:0] frame_div_reg;
	reg [15:0] frame_cnt_reg;
	reg [15:0] frame_cnt_next;
	reg frame_toggle;
	reg [31:0] rd_next;
	reg display_on_next;
	reg [1:0] disp_mode_next;
	reg [2:0] addr_map_next;
	reg [6:0] start_line_next;
	reg [6:0] col_addr_next;
	reg [7:0] contrast_next;

	// One-hot register select, shared by the read mux and the write path
	function [7:0] decode;
		input [7:0] addr;
		begin
			decode = 8'h00;
			if (addr == `OPRS_ADDR_CTRL) begin
				decode[`OPRS_SEL_CTRL] = 1'b1;
			end else if (addr == `OPRS_ADDR_MODE) begin
				decode[`OPRS_SEL_MODE] = 1'b1;
			end else if (addr == `OPRS_ADDR_MAP) begin
				decode[`OPRS_SEL_MAP] = 1'b1;
			end else if (addr == `OPRS_ADDR_START) begin
				decode[`OPRS_SEL_START] = 1'b1;
			end else if (addr == `OPRS_ADDR_COL) begin
				decode[`OPRS_SEL_COL] = 1'b1;
			end else if (addr == `OPRS_ADDR_CONTRAST) begin
				decode[`OPRS_SEL_CONTRAST] = 1'b1;
			end else if (addr == `OPRS_ADDR_STATUS) begin
				decode[`OPRS_SEL_STATUS] = 1'b1;
			end else if (addr == `OPRS_ADDR_FRAME_DIV) begin
				decode[`OPRS_SEL_FRAME_DIV] = 1'b1;
			end
		end
	endfunction

	// The pin is asynchronous to the bus clock, so only the second stage is read
	oprs_sync2 u_sync (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.async_i(hard_init_low_i),
		.sync_o(init_sync)
	);

	// Pin low (synchronised) or a soft init both hold the defaults
	assign hold_init = ~init_sync | soft_init_reg;
	assign take = hsel_i & hready_i & htrans_i[`OPRS_HTRANS_NONSEQ_BIT];
	// Sub-word writes are dropped rather than merged into a register
	assign word_size = (hsize_i == `OPRS_HSIZE_WORD);
	assign rd_sel = decode(haddr_i);
	assign wr_sel = wr_pend_reg ? decode(wr_addr_reg) : 8'h00;
	assign soft_init_next = wr_sel[`OPRS_SEL_CTRL] & hwdata_i[`OPRS_CTRL_SOFT_INIT_BIT];
	assign frame_run = display_on_o & ~hold_init;

	// Read mux; unused upper bits read as zero
	always @* begin
		rd_next = 32'h0000_0000;
		if (rd_sel[`OPRS_SEL_CTRL]) begin
			rd_next[`OPRS_CTRL_DISP_ON_BIT] = display_on_o;
			rd_next[`OPRS_CTRL_SOFT_INIT_BIT] = soft_init_reg;
		end else if (rd_sel[`OPRS_SEL_MODE]) begin
			rd_next[`OPRS_MODE_MSB:0] = disp_mode_o;
		end else if (rd_sel[`OPRS_SEL_MAP]) begin
			rd_next[`OPRS_MAP_MSB:0] = addr_map_o;
		end else if (rd_sel[`OPRS_SEL_START]) begin
			rd_next[`OPRS_LINE_MSB:0] = start_line_o;
		end else if (rd_sel[`OPRS_SEL_COL]) begin
			rd_next[`OPRS_LINE_MSB:0] = col_addr_o;
		end else if (rd_sel[`OPRS_SEL_CONTRAST]) begin
			rd_next[`OPRS_CONTRAST_MSB:0] = contrast_o;
		end else if (rd_sel[`OPRS_SEL_STATUS]) begin
			rd_next[`OPRS_STATUS_INIT_BIT] = init_sync;
			rd_next[`OPRS_STATUS_FRAME_BIT] = frame_rate_pulse_out_o;
		end else if (rd_sel[`OPRS_SEL_FRAME_DIV]) begin
			rd_next[`OPRS_DIV_MSB:0] = frame_div_reg;
		end
	end

	// Bus slave: zero wait states, always OKAY, unmapped reads give zero
	always @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			hrdata_o <= 32'h0000_0000;
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end else begin
			wr_pend_reg <= take & hwrite_i & word_size;
			if (take) begin
				wr_addr_reg <= haddr_i;
			end
			if (take & ~hwrite_i) begin
				hrdata_o <= rd_next;
			end
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end
	end

	// Write data stands in the data phase, one cycle after the address
	always @* begin
		display_on_next = display_on_o;
		disp_mode_next = disp_mode_o;
		addr_map_next = addr_map_o;
		start_line_next = start_line_o;
		col_addr_next = col_addr_o;
		contrast_next = contrast_o;
		if (wr_sel[`OPRS_SEL_CTRL]) begin
			display_on_next = hwdata_i[`OPRS_CTRL_DISP_ON_BIT];
		end
		if (wr_sel[`OPRS_SEL_MODE]) begin
			disp_mode_next = hwdata_i[`OPRS_MODE_MSB:0];
		end
		if (wr_sel[`OPRS_SEL_MAP]) begin
			addr_map_next = hwdata_i[`OPRS_MAP_MSB:0];
		end
		if (wr_sel[`OPRS_SEL_START]) begin
			start_line_next = hwdata_i[`OPRS_LINE_MSB:0];
		end
		if (wr_sel[`OPRS_SEL_COL]) begin
			col_addr_next = hwdata_i[`OPRS_LINE_MSB:0];
		end
		if (wr_sel[`OPRS_SEL_CONTRAST]) begin
			contrast_next = hwdata_i[`OPRS_CONTRAST_MSB:0];
		end
	end

	// Display state; defaults win while init is held, so writes then are dropped
	always @(posedge ref_clk_i) begin
		if (sys_rst_i | hold_init) begin
			display_on_o <= 1'b0;
			disp_mode_o <= `OPRS_MODE_480X128;
			addr_map_o <= `OPRS_MAP_RST;
			start_line_o <= `OPRS_START_RST;
			col_addr_o <= `OPRS_COL_RST;
			contrast_o <= `OPRS_CONTRAST_RST;
		end else begin
			display_on_o <= display_on_next;
			disp_mode_o <= disp_mode_next;
			addr_map_o <= addr_map_next;
			start_line_o <= start_line_next;
			col_addr_o <= col_addr_next;
			contrast_o <= contrast_next;
		end
	end

	// Soft init is a self-clearing one-cycle hold; divider is not reset by init
	always @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			soft_init_reg <= 1'b0;
			frame_div_reg <= `OPRS_FRAME_DIV_RST;
		end else begin
			soft_init_reg <= soft_init_next;
			if (wr_sel[`OPRS_SEL_FRAME_DIV]) begin
				frame_div_reg <= hwdata_i[`OPRS_DIV_MSB:0];
			end
		end
	end

	// Compare with >= so a divider lowered below the running count restarts at once
	always @* begin
		frame_cnt_next = frame_cnt_reg + 16'h0001;
		frame_toggle = 1'b0;
		if (frame_cnt_reg >= frame_div_reg) begin
			frame_cnt_next = 16'h0000;
			frame_toggle = 1'b1;
		end
	end

	// Frame trigger toggles each divider period while the display is driven
	always @(posedge ref_clk_i) begin
		if (sys_rst_i | ~frame_run) begin
			frame_cnt_reg <= 16'h0000;
			frame_rate_pulse_out_o <= 1'b0;
		end else begin
			frame_cnt_reg <= frame_cnt_next;
			if (frame_toggle) begin
				frame_rate_pulse_out_o <= ~frame_rate_pulse_out_o;
			end
		end
	end
endmodule

//--- testbench/oprs_core_monitor.sv
// Checker on reset defaults and frame output
`timescale 1ns/100ps
module oprs_core_monitor (
	input wire ref_clk_i,
	input wire sys_rst_i,
	input wire hard_init_low_i,
	input wire display_on_o,
	input wire [1:0] disp_mode_o,
	input wire [2:0] addr_map_o,
	input wire [6:0] start_line_o,
	input wire [6:0] col_addr_o,
	input wire [7:0] contrast_o,
	input wire frame_rate_pulse_out_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	// Four samples span the pin synchroniser and the output register
	sequence s_init; (!hard_init_low_i)[*4]; endsequence
	property p_off; s_init |-> !display_on_o; endproperty
	a_off: assert property (p_off) else $error("init: on");
	property p_mode; s_init |-> disp_mode_o == 2'h0; endproperty
	a_mode: assert property (p_mode) else $error("init: mode");
	property p_map; s_init |-> addr_map_o[1:0] == 2'h0; endproperty
	a_map: assert property (p_map) else $error("init: map");
	property p_start; s_init |-> start_line_o == 7'h00; endproperty
	a_start: assert property (p_start) else $error("init: start");
	property p_col; s_init |-> col_addr_o == 7'h00; endproperty
	a_col: assert property (p_col) else $error("init: col");
	property p_scan; s_init |-> !addr_map_o[2]; endproperty
	a_scan: assert property (p_scan) else $error("init: scan");
	property p_con; s_init |-> contrast_o == 8'h7F; endproperty
	a_con: assert property (p_con) else $error("init: contrast");
	property p_frame; (!display_on_o)[*3] |-> !frame_rate_pulse_out_o; endproperty
	a_frame: assert property (p_frame) else $error("frame while off");
	cover property (s_init);
	cover property ($rose(frame_rate_pulse_out_o));
	cover property ($fell(display_on_o));
endmodule
bind oprs_core oprs_core_monitor u_oprs_core_monitor (
	.ref_clk_i(ref_clk_i),
	.sys_rst_i(sys_rst_i),
	.hard_init_low_i(hard_init_low_i),
	.display_on_o(display_on_o),
	.disp_mode_o(disp_mode_o),
	.addr_map_o(addr_map_o),
	.start_line_o(start_line_o),
	.col_addr_o(col_addr_o),
	.contrast_o(contrast_o),
	.frame_rate_pulse_out_o(frame_rate_pulse_out_o)
);

//--- testbench/oprs_host.sv
// Host model: init pin, power sequence, bus master
`timescale 1ns/100ps
`include "oprs_map.vh"
module oprs_host #(parameter int WAIT = 20) (
	input wire ref_clk_i,
	input wire hreadyout_o,
	output logic hard_init_low_i = 1'b1,
	output logic [1:0] htrans_i = 2'h0,
	output logic [7:0] haddr_i = 8'h00,
	output logic hwrite_i = 1'b0,
	output logic [31:0] hwdata_i = 32'h0,
	output logic rd_phase = 1'b0
);
	// Panel supply has no device pin, so it is only a flag here
	// Settle waits are shortened to a few cycles to keep runs short
	logic panel_on = 1'b0;
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		htrans_i <= 2'h2;
		haddr_i <= a;
		hwrite_i <= w;
		do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
		htrans_i <= 2'h0;
		hwdata_i <= d;
		rd_phase <= !w;
		do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
		rd_phase <= 1'b0;
	endtask
	task automatic power_up();
		hard_init_low_i <= 1'b0;
		repeat (8) @(posedge ref_clk_i);
		hard_init_low_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		xfer(1'b1, `OPRS_ADDR_CTRL, 32'h0);
		panel_on = 1'b1;
		repeat (WAIT) @(posedge ref_clk_i);
		xfer(1'b1, `OPRS_ADDR_CTRL, 32'h1);
	endtask
	task automatic power_down();
		xfer(1'b1, `OPRS_ADDR_CTRL, 32'h0);
		panel_on = 1'b0;
		repeat (WAIT) @(posedge ref_clk_i);
	endtask
endmodule

//--- testbench/testbench.sv
// Self-checking bench of the display core
`timescale 1ns/100ps
`include "oprs_map.vh"
module testbench;
	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	wire hsel_i = 1'b1;
	wire [2:0] hsize_i = 3'h2;
	wire hard_init_low_i, hwrite_i, rd_phase, hready_i, hreadyout_o, hresp_o;
	wire display_on_o, frame_rate_pulse_out_o;
	wire [1:0] htrans_i, disp_mode_o;
	wire [2:0] addr_map_o;
	wire [7:0] haddr_i, contrast_o;
	wire [6:0] start_line_o, col_addr_o;
	wire [31:0] hwdata_i, hrdata_o;
	int n_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	int k;
	logic p;
	logic [31:0] v;
	logic [31:0] m;
	logic [31:0] exp_q[$];
	assign hready_i = hreadyout_o;
	oprs_core u_oprs_core (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.hard_init_low_i(hard_init_low_i),
		.hsel_i(hsel_i),
		.haddr_i(haddr_i),
		.htrans_i(htrans_i),
		.hwrite_i(hwrite_i),
		.hsize_i(hsize_i),
		.hwdata_i(hwdata_i),
		.hready_i(hready_i),
		.hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o),
		.hresp_o(hresp_o),
		.display_on_o(display_on_o),
		.disp_mode_o(disp_mode_o),
		.addr_map_o(addr_map_o),
		.start_line_o(start_line_o),
		.col_addr_o(col_addr_o),
		.contrast_o(contrast_o),
		.frame_rate_pulse_out_o(frame_rate_pulse_out_o)
	);
	oprs_host u_oprs_host (
		.ref_clk_i(ref_clk_i),
		.hreadyout_o(hreadyout_o),
		.hard_init_low_i(hard_init_low_i),
		.htrans_i(htrans_i),
		.haddr_i(haddr_i),
		.hwrite_i(hwrite_i),
		.hwdata_i(hwdata_i),
		.rd_phase(rd_phase)
	);
	task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e) begin
			n_errors++;
			$display("BAD %s exp %h got %h", what, e, s);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		u_oprs_host.xfer(1'b0, a, $urandom);
	endtask
	task automatic defaults();
		for (int i = 1; i < 6; i++)
			rd(8'(4 * i), (i == 5) ? 32'h7F : 32'h0);
	endtask
	task automatic end_of_test();
		if (n_errors == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge ref_clk_i) begin
		cycles++;
		if (rd_phase === 1'b1) begin
			cmp("hrdata", exp_q.pop_front(), hrdata_o);
			cmp("bus response", 32'h0000_0002, {30'h0, hreadyout_o, hresp_o});
		end
		if (cycles == 20000) begin
			n_errors++;
			end_of_test();
		end
	end
	initial begin
		forever #50 ref_clk_i = ~ref_clk_i;
	end
	initial begin
		v = $urandom(32'hC2CC);
		repeat (12) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		rd(`OPRS_ADDR_CTRL, 32'h0);
		defaults();
		rd(8'h20, 32'h0);
		for (int i = 1; i < 6; i++) begin
			v = $urandom;
			m = (i == 1) ? 32'h3 : (i == 2) ? 32'h7 : (i == 5) ? 32'hFF : 32'h7F;
			u_oprs_host.xfer(1'b1, 8'(4 * i), v);
			rd(8'(4 * i), v & m);
		end
		u_oprs_host.power_up();
		defaults();
		rd(`OPRS_ADDR_CTRL, 32'h1);
		u_oprs_host.xfer(1'b1, `OPRS_ADDR_FRAME_DIV, 32'h3);
		repeat (10) @(posedge ref_clk_i);
		#1 p = frame_rate_pulse_out_o;
		k = 0;
		repeat (40) begin
			@(posedge ref_clk_i);
			#1 k += (frame_rate_pulse_out_o !== p);
			p = frame_rate_pulse_out_o;
		end
		cmp("frame toggles", 32'h0000_000A, 32'(k));
		rd(`OPRS_ADDR_FRAME_DIV, 32'h3);
		u_oprs_host.power_up();
		defaults();
		rd(`OPRS_ADDR_CTRL, 32'h1);
		u_oprs_host.xfer(1'b1, `OPRS_ADDR_CONTRAST, $urandom);
		u_oprs_host.xfer(1'b1, `OPRS_ADDR_CTRL, 32'h3);
		rd(`OPRS_ADDR_CTRL, 32'h0);
		rd(`OPRS_ADDR_CONTRAST, 32'h7F);
		u_oprs_host.power_down();
		rd(`OPRS_ADDR_CTRL, 32'h0);
		rd(`OPRS_ADDR_STATUS, 32'h1);
		repeat (4) @(posedge ref_clk_i);
		end_of_test();
	end
endmodule
